// ---- bdpd_pkg.sv ----
// constants shared by the bidirectional port d block
package bdpd_pkg;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_VALUE = 8'h00;
  localparam logic [7:0] OFF_DIRECTION = 8'h04;
  localparam logic [7:0] OFF_LATCH = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic RST_SELECT = 1'h0;
  localparam int CTRL_SELECT_BIT = 0;
  localparam int STAT_SLAVE_BIT = 0;
  localparam int STAT_MULTI_BIT = 1;
  localparam int PWM_B_PIN = 5;
  localparam int PWM_C_PIN = 6;
  localparam int PWM_D_PIN = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- bdpd_pad_if.sv ----
// carrier between register core and pin cells
`timescale 1ns/1ps
interface bdpd_pad_if;
  logic [7:0] dir;
  logic [7:0] lat;
  logic [2:0] pwm_en;
  logic [2:0] pwm_val;
  logic [7:0] pin_sample;
  modport core (output dir, output lat, output pwm_en, output pwm_val, input pin_sample);
  modport pad (input dir, input lat, input pwm_en, input pwm_val, output pin_sample);
endinterface

// ---- bdpd_pad.sv ----
// registered pin cells: driver, enable and input sample per pin
`timescale 1ns/1ps
module bdpd_pad (
  input wire logic aclk,
  input wire logic aresetn,
  bdpd_pad_if.pad p,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe
);
  logic [7:0] drive_d;
  logic [7:0] sample_q;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      wire hit_b = (i == bdpd_pkg::PWM_B_PIN) && p.pwm_en[0];
      wire hit_c = (i == bdpd_pkg::PWM_C_PIN) && p.pwm_en[1];
      wire hit_d = (i == bdpd_pkg::PWM_D_PIN) && p.pwm_en[2];
      // pwm owns the pin value while in use; direction still gates the driver
      assign drive_d[i] = hit_b ? p.pwm_val[0] : hit_c ? p.pwm_val[1] :
                          hit_d ? p.pwm_val[2] : p.lat[i];
    end
  endgenerate

  // one process for all pins keeps each vector with a single writer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe <= 8'h00;
      pin_o <= 8'h00;
      sample_q <= 8'h00;
    end else begin
      pin_oe <= ~p.dir;
      pin_o <= drive_d;
      sample_q <= pin_i;
    end
  end

  assign p.pin_sample = sample_q;

  property p_pwm_route;
    @(posedge aclk) disable iff (!aresetn)
      p.pwm_en[0] |=> pin_o[bdpd_pkg::PWM_B_PIN] == $past(p.pwm_val[0]);
  endproperty
  a_pwm_route: assert property (p_pwm_route) else $error("pwm b not routed");

  property p_sample;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |=> sample_q == $past(pin_i);
  endproperty
  a_sample: assert property (p_sample) else $error("pin sample stale");
endmodule

// ---- bdpd_port.sv ----
// eight-bit bidirectional port with axi4-lite register access
`timescale 1ns/1ps
module bdpd_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe,
  input wire logic [2:0] pwm_route_en,
  input wire logic [2:0] pwm_output_bcd,
  input wire logic pwm_multi_output,
  output logic parallel_slave_port_active
);
  bdpd_pad_if pif ();

  logic [7:0] dir_q;
  logic [7:0] lat_q;
  logic select_q;
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic slave_mode_q;

  // write channel: address and data held independently, committed together
  wire aw_hs = s_axi_awvalid & awready_q;
  wire w_hs = s_axi_wvalid & wready_q;
  wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d = (aw_full_q | aw_hs) & ~wr_go;
  wire w_full_d = (w_full_q | w_hs) & ~wr_go;
  wire bvalid_d = wr_go | (bvalid_q & ~s_axi_bready);
  wire wr_lane = wr_go & wstrb_q;
  wire wr_value = wr_lane && (awaddr_q == bdpd_pkg::OFF_VALUE);
  wire wr_dir = wr_lane && (awaddr_q == bdpd_pkg::OFF_DIRECTION);
  wire wr_lat = wr_lane && (awaddr_q == bdpd_pkg::OFF_LATCH);
  wire wr_ctrl = wr_lane && (awaddr_q == bdpd_pkg::OFF_CONTROL);
  wire wr_known = (awaddr_q == bdpd_pkg::OFF_VALUE) || (awaddr_q == bdpd_pkg::OFF_DIRECTION) ||
                  (awaddr_q == bdpd_pkg::OFF_LATCH) || (awaddr_q == bdpd_pkg::OFF_CONTROL) ||
                  (awaddr_q == bdpd_pkg::OFF_STATUS);
  // value writes land in the latch, never on pins directly
  wire [7:0] lat_d = (wr_value | wr_lat) ? wdata_q : lat_q;

  // read channel
  wire ar_hs = s_axi_arvalid & arready_q;
  wire rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready);
  wire [7:0] status_word = {6'h00, pwm_multi_output, slave_mode_q};
  logic [7:0] rd_byte;
  logic rd_known;
  always_comb begin
    rd_known = 1'b1;
    case (s_axi_araddr)
      bdpd_pkg::OFF_VALUE: rd_byte = pif.pin_sample;
      bdpd_pkg::OFF_DIRECTION: rd_byte = dir_q;
      bdpd_pkg::OFF_LATCH: rd_byte = lat_q;
      bdpd_pkg::OFF_CONTROL: rd_byte = {7'h00, select_q};
      bdpd_pkg::OFF_STATUS: rd_byte = status_word;
      default: begin
        rd_byte = 8'h00;
        rd_known = 1'b0;
      end
    endcase
  end

  // microprocessor mode gives way to multi-output pwm
  wire slave_mode_d = select_q & ~pwm_multi_output;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= bdpd_pkg::RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
      end
      // ready stays low while a word is held or a response is pending
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (wr_go) begin
        bresp_q <= wr_known ? bdpd_pkg::RESP_OKAY : bdpd_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= bdpd_pkg::RST_DIRECTION;
      lat_q <= bdpd_pkg::RST_LATCH;
      select_q <= bdpd_pkg::RST_SELECT;
      slave_mode_q <= 1'b0;
    end else begin
      if (wr_dir) begin
        dir_q <= wdata_q;
      end
      lat_q <= lat_d;
      if (wr_ctrl) begin
        select_q <= wdata_q[bdpd_pkg::CTRL_SELECT_BIT];
      end
      slave_mode_q <= slave_mode_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= bdpd_pkg::RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_hs) begin
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= rd_known ? bdpd_pkg::RESP_OKAY : bdpd_pkg::RESP_SLVERR;
      end
    end
  end

  assign pif.dir = dir_q;
  assign pif.lat = lat_q;
  assign pif.pwm_en = pwm_route_en;
  assign pif.pwm_val = pwm_output_bcd;

  bdpd_pad u_pad (
    .aclk(aclk),
    .aresetn(aresetn),
    .p(pif.pad),
    .pin_i(pin_i),
    .pin_o(pin_o),
    .pin_oe(pin_oe)
  );

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign parallel_slave_port_active = slave_mode_q;

  // checks
  property p_input_off;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> (pin_oe & $past(dir_q)) == 8'h00;
  endproperty
  a_input_off: assert property (p_input_off) else $error("input pin driven");

  property p_drive_latch;
    @(posedge aclk) disable iff (!aresetn)
      (pwm_route_en == 3'h0) |=> (pin_oe & (pin_o ^ $past(lat_q))) == 8'h00;
  endproperty
  a_drive_latch: assert property (p_drive_latch) else $error("pin not from latch");

  sequence s_latch_read;
    ar_hs && (s_axi_araddr == bdpd_pkg::OFF_LATCH);
  endsequence
  property p_latch_read;
    @(posedge aclk) disable iff (!aresetn)
      s_latch_read |=> s_axi_rvalid && (s_axi_rdata[7:0] == $past(lat_q));
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch readback wrong");

  property p_reset_inputs;
    @(posedge aclk) !aresetn |=> dir_q == bdpd_pkg::RST_DIRECTION && pin_oe == 8'h00;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs");

  property p_slave_on;
    @(posedge aclk) disable iff (!aresetn)
      (select_q && !pwm_multi_output) |=> parallel_slave_port_active;
  endproperty
  a_slave_on: assert property (p_slave_on) else $error("port mode not entered");

  property p_slave_off;
    @(posedge aclk) disable iff (!aresetn)
      pwm_multi_output |=> !parallel_slave_port_active;
  endproperty
  a_slave_off: assert property (p_slave_off) else $error("port mode not disabled");

  sequence s_value_write;
    wr_go && wstrb_q && (awaddr_q == bdpd_pkg::OFF_VALUE);
  endsequence
  property p_value_write;
    @(posedge aclk) disable iff (!aresetn)
      s_value_write |=> lat_q == $past(wdata_q) ##1 (pin_o | ~pin_oe) == (lat_q | ~pin_oe)
        || pwm_route_en != 3'h0;
  endproperty
  a_value_write: assert property (p_value_write) else $error("value write lost");

  sequence s_dir_cf;
    wr_go && wstrb_q && (awaddr_q == bdpd_pkg::OFF_DIRECTION) && (wdata_q == 8'hcf);
  endsequence
  property p_dir_cf;
    @(posedge aclk) disable iff (!aresetn)
      s_dir_cf |=> ##1 pin_oe == 8'h30;
  endproperty
  a_dir_cf: assert property (p_dir_cf) else $error("direction map wrong");

  property p_value_read;
    @(posedge aclk) disable iff (!aresetn)
      (ar_hs && s_axi_araddr == bdpd_pkg::OFF_VALUE) |=> s_axi_rdata[7:0] == $past(pif.pin_sample);
  endproperty
  a_value_read: assert property (p_value_read) else $error("pin read wrong");

  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn)
      (aw_full_q && w_full_q && !bvalid_q) |=> s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no write response");

  property p_pwm_c_route;
    @(posedge aclk) disable iff (!aresetn)
      pwm_route_en[1] |=> pin_o[bdpd_pkg::PWM_C_PIN] == $past(pwm_output_bcd[1]);
  endproperty
  a_pwm_c_route: assert property (p_pwm_c_route) else $error("pwm c not routed");

  property p_pwm_d_route;
    @(posedge aclk) disable iff (!aresetn)
      pwm_route_en[2] |=> pin_o[bdpd_pkg::PWM_D_PIN] == $past(pwm_output_bcd[2]);
  endproperty
  a_pwm_d_route: assert property (p_pwm_d_route) else $error("pwm d not routed");

  property p_dir_write;
    @(posedge aclk) disable iff (!aresetn)
      wr_dir |=> dir_q == $past(wdata_q);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  // the latch moves only on a register write, never with pin levels
  property p_latch_hold;
    @(posedge aclk) disable iff (!aresetn)
      !(wr_value || wr_lat) |=> lat_q == $past(lat_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

  property p_oe_follow;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> pin_oe == ~$past(dir_q);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("driver not per direction bit");

  property p_select_write;
    @(posedge aclk) disable iff (!aresetn)
      wr_ctrl |=> select_q == $past(wdata_q[bdpd_pkg::CTRL_SELECT_BIT]);
  endproperty
  a_select_write: assert property (p_select_write) else $error("select write lost");

  property p_status_read;
    @(posedge aclk) disable iff (!aresetn)
      (ar_hs && s_axi_araddr == bdpd_pkg::OFF_STATUS) |=>
        s_axi_rdata[7:0] == {6'h00, $past(pwm_multi_output), $past(slave_mode_q)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn)
      ar_hs |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("no read response");
endmodule

// ---- bdpd_pin_model.sv ----
// external pin model: resolves each pad from device drive and outside level
`timescale 1ns/1ps
module bdpd_pin_model (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext,
  output logic [7:0] pin_i
);
  // an undriven pad shows the outside level, a driven pad the device value
  assign pin_i = (pin_o & pin_oe) | (ext & ~pin_oe);
endmodule

// ---- tb_bidir_port_d_gpio.sv ----
// self-checking bench for the bidirectional port block
`timescale 1ns/1ps
module tb_bidir_port_d_gpio;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0, ext = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, multi = 0;
  logic [31:0] wdata = 0, seed = 32'he7d6, d;
  logic [3:0] wstrb = 0, strb = 4'h1;
  logic [2:0] pen = 0, pval = 0;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, slave_act;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pin_i, pin_o, pin_oe;
  int fail_count = 0, n_compared = 0, m_dir = 8'hff, m_lat = 0, e;
  always #2 aclk = ~aclk;
  bdpd_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .pwm_route_en(pen), .pwm_output_bcd(pval), .pwm_multi_output(multi),
    .parallel_slave_port_active(slave_act));
  bdpd_pin_model pins_u (.pin_o(pin_o), .pin_oe(pin_oe), .ext(ext), .pin_i(pin_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // handshakes are judged on values seen at the falling edge, which the
  // registered outputs keep up to the next rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1; wdata <= {24'h0, v}; wstrb <= strb;
    wvalid <= 1; bready <= 1;
    // no cycle count is assumed here; only the watchdog ends a hung wait
    forever begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 0;
      if (hw) wvalid <= 0;
      if (hb) begin
        bready <= 0;
        return;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 0;
      if (hr) begin
        rready <= 0;
        return;
      end
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask
  initial begin
    #40000;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    settle();
    chk(pin_oe, 8'h00);
    rd(bdpd_pkg::OFF_DIRECTION);
    chk(d, m_dir);
    wr(bdpd_pkg::OFF_DIRECTION, 8'hcf);
    settle();
    chk(pin_oe, 8'h30);
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      ext <= 8'(rnd());
      m_dir = rnd() & 8'hff;
      m_lat = rnd() & 8'hff;
      wr(bdpd_pkg::OFF_DIRECTION, m_dir[7:0]);
      // odd passes load the latch through the value register
      wr(i[0] ? bdpd_pkg::OFF_VALUE : bdpd_pkg::OFF_LATCH, m_lat[7:0]);
      settle();
      chk(pin_oe, ~m_dir & 8'hff);
      chk(pin_o & pin_oe, m_lat & ~m_dir & 8'hff);
      rd(bdpd_pkg::OFF_LATCH);
      chk(d, m_lat);
      chk(r, bdpd_pkg::RESP_OKAY);
      rd(bdpd_pkg::OFF_VALUE);
      chk(d, (m_lat & ~m_dir & 8'hff) | (ext & m_dir));
    end
    // a write with lane 0 off must leave the latch alone
    strb = 4'h0;
    wr(bdpd_pkg::OFF_LATCH, ~m_lat[7:0]);
    strb = 4'h1;
    chk(r, bdpd_pkg::RESP_OKAY);
    rd(bdpd_pkg::OFF_LATCH);
    chk(d, m_lat);
    wr(bdpd_pkg::OFF_DIRECTION, 8'h00);
    m_dir = 0;
    for (int k = 0; k < 8; k++) begin
      @(posedge aclk);
      pen <= k[2:0];
      pval <= 3'(rnd());
      settle();
      e = m_lat & 8'h1f;
      for (int b = 0; b < 3; b++) e |= (pen[b] ? pval[b] : m_lat[5 + b]) << (5 + b);
      chk(pin_o, e);
    end
    wr(bdpd_pkg::OFF_CONTROL, 8'h01);
    settle();
    chk(slave_act, 1'b1);
    @(posedge aclk);
    multi <= 1;
    settle();
    chk(slave_act, 1'b0);
    rd(bdpd_pkg::OFF_STATUS);
    chk(d, 32'h2);
    wr(8'h40, 8'hff);
    chk(r, bdpd_pkg::RESP_SLVERR);
    rd(8'h40);
    chk(r, bdpd_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    complete_run();
  end
endmodule
